// *** logic/sbp_pkg.sv ***
// Constants and carrier types for the serial bus PHY base register bank
package sbp_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [4:0] SBP_IDX_GAP = 5'h01;
   localparam logic [4:0] SBP_IDX_CAPS = 5'h02;
   localparam logic [4:0] SBP_IDX_SPEED = 5'h03;
   localparam logic [4:0] SBP_IDX_SELF = 5'h04;
   localparam logic [4:0] SBP_IDX_EVT = 5'h05;
   localparam logic [4:0] SBP_IDX_ISTAT = 5'h10;
   localparam logic [4:0] SBP_IDX_IMASK = 5'h11;
   // Reset values and constant fields
   localparam logic [5:0] SBP_GAP_RST = 6'h3F;
   localparam logic [2:0] SBP_EXT_VAL = 3'h7;
   localparam logic [3:0] SBP_PORTS_VAL = 4'h1;
   localparam logic [2:0] SBP_SPEED_VAL = 3'h2;
   localparam logic [3:0] SBP_DELAY_VAL = 4'h0;
   localparam logic [2:0] SBP_JITTER_VAL = 3'h0;
   localparam logic SBP_LINK_ACTIVE_CTL_RST = 1'h1;
   localparam logic SBP_C_RST = 1'h0;
   localparam logic SBP_WDOG_RST = 1'h0;
   // Field positions inside the low byte
   localparam int SBP_LINK_ACTIVE_CTL_BIT = 7;
   localparam int SBP_C_BIT = 6;
   localparam int SBP_WDOG_BIT = 7;
   localparam int SBP_PEVT_BIT = 2;
   // Interrupt status and mask layout
   localparam int SBP_IRQ_W = 2;
   localparam int SBP_IRQ_PEVT = 0;
   localparam int SBP_IRQ_GAP = 1;
   // Edges after reset release before the strap synchroniser is settled
   localparam logic [2:0] SBP_STRAP_WAIT = 3'h5;
   // Avalon response codes
   localparam logic [1:0] SBP_RESP_OK = 2'h0;
   localparam logic [1:0] SBP_RESP_DECERR = 2'h3;

   typedef struct packed {
      logic link_active;
      logic contender;
      logic [2:0] pwr_class;
   } sbp_selfid_type;

   typedef struct packed {
      logic valid;
      logic [5:0] gap;
   } sbp_phy_cfg_type;
endpackage : sbp_pkg

// *** logic/sbp_regs.sv ***
// Base register bank of the serial bus PHY with Avalon-MM access
`timescale 1ns/10ps
// Notes on behaviour
// - A six-bit gap count is set by register write or config packet.
// - Hardware reset loads the gap count with 3Fh.
// - Two bus resets with no gap update between them restore 3Fh.
// - The extended field always reads 111b.
// - The port count field always reads one.
// - The speed field always reads 010b for S400.
// - The repeater delay field always reads zero.
// - Self-ID bit 9 is link-active control AND link power status.
// - Link-active control is one after hardware reset, kept on bus reset.
// - The link interface follows link power status alone.
// - A writable contender bit is copied to self-ID bit 20.
// - The repeater jitter field always reads zero.
// - A writable power class is copied to self-ID bits 21 to 23.
// - Power class loads from the straps on hardware reset only.
// - With watchdog set, a resume start sets the port event flag.
// - Watchdog enable is zero after hardware reset, kept on bus reset.
module sbp_regs #(
   parameter int NUM_PORTS = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [6:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic [1:0] avs_response,
   output logic avs_waitrequest,
   output logic irq,
   // Link pins
   input wire logic link_power_status_in,
   input wire logic link_request_in,
   input wire logic [2:0] power_class_straps,
   // PHY core events
   input wire logic bus_reset_pulse,
   input wire sbp_pkg::sbp_phy_cfg_type phy_config,
   input wire logic [NUM_PORTS-1:0] resume_start,
   // Outputs to PHY core and link
   output logic [5:0] gap_count_out,
   output sbp_pkg::sbp_selfid_type selfid,
   output logic link_if_active,
   output logic link_request_valid
);
   logic wait_r;
   logic [31:0] rdata_r;
   logic [1:0] resp_r;
   logic irq_r;
   logic [5:0] gap_r, gap_nxt;
   logic armed_r, armed_nxt;
   logic link_active_ctl_r, contender_r, wdog_r;
   logic [2:0] pwr_r;
   logic [2:0] strap_cnt_r;
   logic strap_done_r;
   logic [sbp_pkg::SBP_IRQ_W-1:0] istat_r, istat_nxt, imask_r;
   logic link_request_in_valid_r;
   logic lps_s, link_request_in_s;
   logic [2:0] strap_s;

   // Bus decode
   wire [4:0] idx = avs_address[6:2];
   wire req = avs_read | avs_write;
   wire take = req & wait_r;
   wire wr_acc = avs_write & ~wait_r;
   wire sel_gap = idx == sbp_pkg::SBP_IDX_GAP;
   wire sel_caps = idx == sbp_pkg::SBP_IDX_CAPS;
   wire sel_speed = idx == sbp_pkg::SBP_IDX_SPEED;
   wire sel_self = idx == sbp_pkg::SBP_IDX_SELF;
   wire sel_evt = idx == sbp_pkg::SBP_IDX_EVT;
   wire sel_istat = idx == sbp_pkg::SBP_IDX_ISTAT;
   wire sel_imask = idx == sbp_pkg::SBP_IDX_IMASK;
   wire mapped = sel_gap | sel_caps | sel_speed | sel_self | sel_evt |
      sel_istat | sel_imask;
   wire [7:0] wb = avs_writedata[7:0];

   // Read data; unimplemented bits read zero
   wire [7:0] rd_gap = {2'h0, gap_r};
   wire [7:0] rd_caps = {sbp_pkg::SBP_EXT_VAL, 1'h0,
      sbp_pkg::SBP_PORTS_VAL};
   wire [7:0] rd_speed = {sbp_pkg::SBP_SPEED_VAL, 1'h0,
      sbp_pkg::SBP_DELAY_VAL};
   wire [7:0] rd_self = {link_active_ctl_r, contender_r,
      sbp_pkg::SBP_JITTER_VAL, pwr_r};
   wire [7:0] rd_evt = {wdog_r, 4'h0,
      istat_r[sbp_pkg::SBP_IRQ_PEVT], 2'h0};
   wire [7:0] rd_istat = {6'h0, istat_r};
   wire [7:0] rd_imask = {6'h0, imask_r};
   wire [7:0] rd_mux = sel_gap ? rd_gap :
      sel_caps ? rd_caps :
      sel_speed ? rd_speed :
      sel_self ? rd_self :
      sel_evt ? rd_evt :
      sel_istat ? rd_istat :
      sel_imask ? rd_imask : 8'h00;

   // One wait cycle per access, then a single ready cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 1'h1;
         rdata_r <= 32'h0000_0000;
         resp_r <= sbp_pkg::SBP_RESP_OK;
      end else begin
         wait_r <= ~take;
         if (take) begin
            rdata_r <= avs_read ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            resp_r <= mapped ? sbp_pkg::SBP_RESP_OK :
               sbp_pkg::SBP_RESP_DECERR;
         end
      end
   end

   // Gap count: a write wins over a config packet in the same cycle
   wire gap_wr = wr_acc & sel_gap;
   wire gap_upd = gap_wr | phy_config.valid;
   wire gap_restore = bus_reset_pulse & armed_r & ~gap_upd;
   always_comb begin
      gap_nxt = gap_r;
      if (gap_wr) gap_nxt = wb[5:0];
      else if (phy_config.valid) gap_nxt = phy_config.gap;
      else if (gap_restore) gap_nxt = sbp_pkg::SBP_GAP_RST;
   end
   // Armed by one bus reset; an update disarms it
   assign armed_nxt = gap_upd ? 1'h0 :
      (bus_reset_pulse ? 1'h1 : armed_r);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_r <= sbp_pkg::SBP_GAP_RST;
         armed_r <= 1'h0;
      end else begin
         gap_r <= gap_nxt;
         armed_r <= armed_nxt;
      end
   end

   // Pin synchronisers
   sbp_sync3 #(
      .W(5)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d({link_power_status_in, link_request_in, power_class_straps}),
      .q({lps_s, link_request_in_s, strap_s})
   );

   // Control fields; bus reset deliberately has no path here
   wire self_wr = wr_acc & sel_self;
   wire evt_wr = wr_acc & sel_evt;
   wire strap_load = ~strap_done_r & (strap_cnt_r == sbp_pkg::SBP_STRAP_WAIT);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_active_ctl_r <= sbp_pkg::SBP_LINK_ACTIVE_CTL_RST;
         contender_r <= sbp_pkg::SBP_C_RST;
         wdog_r <= sbp_pkg::SBP_WDOG_RST;
         pwr_r <= 3'h0;
         strap_cnt_r <= 3'h0;
         strap_done_r <= 1'h0;
      end else begin
         if (self_wr) begin
            link_active_ctl_r <= wb[sbp_pkg::SBP_LINK_ACTIVE_CTL_BIT];
            contender_r <= wb[sbp_pkg::SBP_C_BIT];
         end
         if (evt_wr) wdog_r <= wb[sbp_pkg::SBP_WDOG_BIT];
         if (!strap_done_r) strap_cnt_r <= strap_cnt_r + 3'h1;
         // Straps are caught once the synchroniser has settled
         if (strap_load) begin
            pwr_r <= strap_s;
            strap_done_r <= 1'h1;
         end else if (self_wr) begin
            pwr_r <= wb[2:0];
         end
      end
   end

   // Interrupt status, set wins over write-one-to-clear
   logic [sbp_pkg::SBP_IRQ_W-1:0] iset, iclr;
   assign iset[sbp_pkg::SBP_IRQ_PEVT] = wdog_r & (|resume_start);
   assign iset[sbp_pkg::SBP_IRQ_GAP] = gap_restore;
   assign iclr[sbp_pkg::SBP_IRQ_PEVT] =
      (wr_acc & sel_istat & avs_writedata[sbp_pkg::SBP_IRQ_PEVT]) |
      (evt_wr & wb[sbp_pkg::SBP_PEVT_BIT]);
   assign iclr[sbp_pkg::SBP_IRQ_GAP] =
      wr_acc & sel_istat & avs_writedata[sbp_pkg::SBP_IRQ_GAP];
   assign istat_nxt = (istat_r & ~iclr) | iset;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_r <= '0;
         imask_r <= '0;
         irq_r <= 1'h0;
      end else begin
         istat_r <= istat_nxt;
         if (wr_acc & sel_imask) imask_r <=
            avs_writedata[sbp_pkg::SBP_IRQ_W-1:0];
         irq_r <= |(istat_r & imask_r);
      end
   end

   // Link requests are serviced whenever link power is up
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) link_request_in_valid_r <= 1'h0;
      else link_request_in_valid_r <= lps_s & link_request_in_s;
   end

   sbp_selfid_build u_selfid (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .link_active_ctl(link_active_ctl_r),
      .lps_active(lps_s),
      .contender(contender_r),
      .pwr_class(pwr_r),
      .selfid(selfid)
   );

   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;
   assign avs_response = resp_r;
   assign irq = irq_r;
   assign gap_count_out = gap_r;
   // Interface state ignores link-active control entirely
   assign link_if_active = lps_s;
   assign link_request_valid = link_request_in_valid_r;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   wire rd_done = avs_read & ~wait_r;

   property p_gap_write;
      gap_wr |=> gap_r == $past(wb[5:0]);
   endproperty
   a_gap_write: assert property (p_gap_write)
      else $error("gap count not taken from write");

   property p_gap_cfg;
      phy_config.valid && !gap_wr |=> gap_r == $past(phy_config.gap);
   endproperty
   a_gap_cfg: assert property (p_gap_cfg)
      else $error("gap count not taken from config packet");

   property p_gap_hwrst;
      $rose(rst_n) |-> gap_r == 6'h3F;
   endproperty
   a_gap_hwrst: assert property (p_gap_hwrst)
      else $error("gap count not 3Fh after reset");

   property p_gap_restore;
      (bus_reset_pulse && !gap_upd) ##1
         (!gap_upd && !bus_reset_pulse)[*3] ##1
         (bus_reset_pulse && !gap_upd) |=> gap_r == 6'h3F;
   endproperty
   a_gap_restore: assert property (p_gap_restore)
      else $error("gap count not restored after two bus resets");

   property p_ext;
      rd_done && sel_caps |-> avs_readdata[7:5] == 3'h7;
   endproperty
   a_ext: assert property (p_ext)
      else $error("extended field wrong");

   property p_ports;
      rd_done && sel_caps |-> avs_readdata[3:0] == 4'h1;
   endproperty
   a_ports: assert property (p_ports)
      else $error("port count wrong");

   property p_speed;
      rd_done && sel_speed |-> avs_readdata[7:5] == 3'h2;
   endproperty
   a_speed: assert property (p_speed)
      else $error("speed field wrong");

   property p_delay;
      rd_done && sel_speed |-> avs_readdata[3:0] == 4'h0;
   endproperty
   a_delay: assert property (p_delay)
      else $error("delay field wrong");

   property p_link_bit;
      ##1 selfid.link_active == ($past(link_active_ctl_r) & $past(lps_s));
   endproperty
   a_link_bit: assert property (p_link_bit)
      else $error("self-ID link bit is not the AND");

   property p_link_active_ctl_keep;
      bus_reset_pulse && !self_wr |=> $stable(link_active_ctl_r);
   endproperty
   a_link_active_ctl_keep: assert property (p_link_active_ctl_keep)
      else $error("link-active control moved on bus reset");

   property p_link_request_in;
      lps_s && link_request_in_s && !link_active_ctl_r |=> link_request_valid;
   endproperty
   a_link_request_in: assert property (p_link_request_in)
      else $error("link request dropped while link-active is clear");

   property p_contender;
      self_wr ##2 1 |-> selfid.contender == $past(wb[6], 2);
   endproperty
   a_contender: assert property (p_contender)
      else $error("contender not copied to self-ID");

   property p_jitter;
      rd_done && sel_self |-> avs_readdata[5:3] == 3'h0;
   endproperty
   a_jitter: assert property (p_jitter)
      else $error("jitter field wrong");

   property p_pwr;
      self_wr && !strap_load ##2 1 |->
         selfid.pwr_class == $past(wb[2:0], 2);
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("power class not copied to self-ID");

   property p_strap;
      strap_load |=> pwr_r == $past(strap_s) && strap_done_r;
   endproperty
   a_strap: assert property (p_strap)
      else $error("power class not loaded from straps");

   property p_pevt;
      wdog_r && (|resume_start) |=> istat_r[0] ##1 irq_r == imask_r[0];
   endproperty
   a_pevt: assert property (p_pevt)
      else $error("port event not set on resume");

   property p_wdog;
      $rose(rst_n) |-> !wdog_r;
   endproperty
   a_wdog: assert property (p_wdog)
      else $error("watchdog enable not clear after reset");

   property p_wdog_keep;
      bus_reset_pulse && !evt_wr |=> $stable(wdog_r);
   endproperty
   a_wdog_keep: assert property (p_wdog_keep)
      else $error("watchdog enable moved on bus reset");

   c_gap_restore: cover property (gap_restore);
   c_pevt_irq: cover property (iset[0] ##[1:20] irq_r);
   c_cfg_gap: cover property (phy_config.valid ##1 gap_r != 6'h3F);
   c_decerr: cover property (rd_done && !mapped);
   c_link_off: cover property (lps_s && link_request_in_s && !link_active_ctl_r);
endmodule : sbp_regs

// *** logic/sbp_selfid_build.sv ***
// Registered self-ID field builder
`timescale 1ns/10ps
module sbp_selfid_build (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register fields and link power state
   input wire logic link_active_ctl,
   input wire logic lps_active,
   input wire logic contender,
   input wire logic [2:0] pwr_class,
   // Self-ID fields
   output sbp_pkg::sbp_selfid_type selfid
);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         selfid <= '0;
      end else begin
         selfid.link_active <= link_active_ctl & lps_active;
         selfid.contender <= contender;
         selfid.pwr_class <= pwr_class;
      end
   end
endmodule : sbp_selfid_build

// *** logic/sbp_sync3.sv ***
// Three-stage synchroniser with agreement filter, one lane per bit
`timescale 1ns/10ps
module sbp_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Lanes
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_lane
         logic s1_r, s2_r, s3_r;
         // First stage feeds only the second stage
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r <= 1'h0;
               s2_r <= 1'h0;
               s3_r <= 1'h0;
               q[i] <= 1'h0;
            end else begin
               s1_r <= d[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) q[i] <= s3_r;
            end
         end
      end
   endgenerate
endmodule : sbp_sync3

// *** verif/sbp_link_model.sv ***
// Behavioural link-layer side that drives the link power and request pins
`timescale 1ns/10ps
module sbp_link_model (
   // Clock
   input wire logic sys_clk,
   // Wanted pin levels from the bench
   input wire logic lps_want,
   input wire logic req_want,
   input wire logic slow,
   // Pins toward the PHY
   output logic link_power_status_in = 1'b0,
   output logic link_request_in = 1'b0
);
   logic lps_d = 1'b0;
   logic req_d = 1'b0;

   // A slow link lags its pins by one more edge
   always @(posedge sys_clk) begin
      lps_d <= lps_want;
      req_d <= req_want;
      link_power_status_in <= slow ? lps_d : lps_want;
      // Request is not gated by power status, so the PHY must do it
      link_request_in <= slow ? req_d : req_want;
   end
endmodule : sbp_link_model

// *** verif/sbp_regs_tb.sv ***
// Self-checking bench for the PHY base register bank
`timescale 1ns/10ps
module sbp_regs_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] avs_address = 7'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [1:0] avs_response;
   logic avs_waitrequest;
   logic irq;
   logic lps_want = 1'b0;
   logic req_want = 1'b0;
   logic slow = 1'b0;
   logic link_power_status_in;
   logic link_request_in;
   logic [2:0] power_class_straps = 3'h5;
   logic bus_reset_pulse = 1'b0;
   sbp_pkg::sbp_phy_cfg_type phy_config = '0;
   logic [0:0] resume_start = 1'h0;
   logic [5:0] gap_count_out;
   sbp_pkg::sbp_selfid_type selfid;
   logic link_if_active;
   logic link_request_valid;
   int error_cnt = 0;
   int checks_done = 0;
   logic [31:0] rd;
   logic [1:0] rsp;

   always #2.5 sys_clk = ~sys_clk;

   sbp_link_model lnk (.sys_clk(sys_clk), .lps_want(lps_want),
      .req_want(req_want), .slow(slow),
      .link_power_status_in(link_power_status_in),
      .link_request_in(link_request_in));

   sbp_regs #(.NUM_PORTS(1)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_response(avs_response),
      .avs_waitrequest(avs_waitrequest), .irq(irq),
      .link_power_status_in(link_power_status_in),
      .link_request_in(link_request_in),
      .power_class_straps(power_class_straps),
      .bus_reset_pulse(bus_reset_pulse), .phy_config(phy_config),
      .resume_start(resume_start), .gap_count_out(gap_count_out),
      .selfid(selfid), .link_if_active(link_if_active),
      .link_request_valid(link_request_valid));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [6:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         error_cnt++;
         $display("mismatch at %0t: bus access timed out", $time);
         complete_run();
      end
   endtask : bus

   task automatic rchk(input logic [6:0] a, input logic [31:0] exp,
      input string msg);
      bus(1'b0, a, 32'h0);
      chk(rd, exp, msg);
   endtask : rchk

   task automatic hw_reset;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      cyc(8);
      rst_n <= 1'b1;
      // Power class is loaded from the straps a few edges after release
      cyc(8);
   endtask : hw_reset

   task automatic breset;
      @(posedge sys_clk);
      bus_reset_pulse <= 1'b1;
      @(posedge sys_clk);
      bus_reset_pulse <= 1'b0;
      cyc(2);
   endtask : breset

   task automatic resume;
      @(posedge sys_clk);
      resume_start <= 1'h1;
      @(posedge sys_clk);
      resume_start <= 1'h0;
   endtask : resume

   task automatic t_defaults;
      rchk(7'h04, 32'h3F, "gap after reset");
      rchk(7'h08, 32'hE1, "caps");
      rchk(7'h0C, 32'h40, "speed and delay");
      rchk(7'h10, 32'h85, "self fields");
      rchk(7'h14, 32'h00, "watchdog");
      bus(1'b1, 7'h08, 32'hFF);
      bus(1'b1, 7'h0C, 32'hFF);
      rchk(7'h08, 32'hE1, "caps after write");
      rchk(7'h0C, 32'h40, "speed after write");
      bus(1'b0, 7'h00, 32'h0);
      chk({30'h0, rsp}, 32'h3, "unmapped response");
      chk({27'h0, selfid}, 32'h05, "selfid idle link");
      $display("test defaults done");
   endtask : t_defaults

   task automatic t_gap;
      bus(1'b1, 7'h04, 32'h12);
      rchk(7'h04, 32'h12, "gap write");
      chk({26'h0, gap_count_out}, 32'h12, "gap out");
      @(posedge sys_clk);
      phy_config <= '{valid: 1'b1, gap: 6'h20};
      @(posedge sys_clk);
      phy_config <= '0;
      cyc(2);
      chk({26'h0, gap_count_out}, 32'h20, "gap by config");
      breset();
      bus(1'b1, 7'h04, 32'h0B);
      breset();
      chk({26'h0, gap_count_out}, 32'h0B, "gap kept");
      breset();
      chk({26'h0, gap_count_out}, 32'h3F, "gap restored");
      rchk(7'h40, 32'h02, "restore status");
      bus(1'b1, 7'h40, 32'h3);
      rchk(7'h40, 32'h00, "status cleared");
      $display("test gap done");
   endtask : t_gap

   task automatic t_link;
      lps_want <= 1'b1;
      req_want <= 1'b1;
      slow <= 1'b1;
      bus(1'b1, 7'h10, 32'h43);
      cyc(10);
      chk({27'h0, selfid}, 32'h0B, "selfid ctl off");
      chk({31'h0, link_if_active}, 32'h1, "if active");
      chk({31'h0, link_request_valid}, 32'h1, "request served");
      slow <= 1'b0;
      bus(1'b1, 7'h10, 32'hC3);
      cyc(2);
      chk({27'h0, selfid}, 32'h1B, "selfid ctl on");
      lps_want <= 1'b0;
      cyc(10);
      chk({27'h0, selfid}, 32'h0B, "selfid power off");
      chk({31'h0, link_request_valid}, 32'h0, "request dropped");
      req_want <= 1'b0;
      breset();
      rchk(7'h10, 32'hC3, "self after bus reset");
      $display("test link done");
   endtask : t_link

   task automatic t_wdog;
      resume();
      cyc(2);
      // Restore stays armed, so the bus reset of the link test set bit 1
      rchk(7'h40, 32'h02, "no event when off");
      bus(1'b1, 7'h14, 32'h80);
      bus(1'b1, 7'h44, 32'h01);
      resume();
      cyc(3);
      chk({31'h0, irq}, 32'h1, "irq raised");
      rchk(7'h14, 32'h84, "port event");
      bus(1'b1, 7'h44, 32'h00);
      cyc(2);
      chk({31'h0, irq}, 32'h0, "irq masked");
      bus(1'b1, 7'h40, 32'h01);
      rchk(7'h40, 32'h02, "event cleared");
      breset();
      rchk(7'h14, 32'h80, "watchdog after bus reset");
      $display("test watchdog done");
   endtask : t_wdog

   task automatic t_hwrst;
      bus(1'b1, 7'h04, 32'h05);
      bus(1'b1, 7'h10, 32'h40);
      power_class_straps <= 3'h2;
      hw_reset();
      rchk(7'h04, 32'h3F, "gap after second reset");
      rchk(7'h10, 32'h82, "self after second reset");
      rchk(7'h14, 32'h00, "watchdog after second reset");
      $display("test hardware reset done");
   endtask : t_hwrst

   initial begin
      cyc(8);
      rst_n <= 1'b1;
      cyc(8);
      t_defaults();
      t_gap();
      t_link();
      t_wdog();
      t_hwrst();
      complete_run();
   end
endmodule : sbp_regs_tb
